/* src/bcr_regs.vh */
// Register offsets, codes, field values and sizes of the command and return-code block
`ifndef BCR_REGS_VH
`define BCR_REGS_VH

// ==========================================================================
// Register byte offsets
`define BCR_OFS_CMD 12'h000
`define BCR_OFS_WDB 12'h004
`define BCR_OFS_RDB 12'h008
`define BCR_OFS_RC 12'h00c
`define BCR_OFS_STAT 12'h010

// ==========================================================================
// Command codes in the low nibble of the command register
`define BCR_CMD_CANCEL 4'h4
`define BCR_CMD_REPLY 4'h5
`define BCR_CMD_LOCK 4'h6
`define BCR_CMD_RXEN 4'h7

// Parameter of set_receive_enable
`define BCR_RXEN_OFF 8'h00
`define BCR_RXEN_ON 8'h01

// Control bits that ask this unit for data
`define BCR_CTRL_RD_LOCK 4'h3
`define BCR_CTRL_RD 4'h7

// Lock status bytes
`define BCR_LOCK_NO 8'h00
`define BCR_LOCK_YES 8'h01

// ==========================================================================
// Return codes
`define BCR_RC_TX_START 4'h0
`define BCR_RC_TX_DONE 4'h2
`define BCR_RC_TX_SHORT 4'h3
`define BCR_RC_MRX_START 4'h4
`define BCR_RC_MRX_FULL 4'h5
`define BCR_RC_MRX_DONE 4'h6
`define BCR_RC_MRX_SHORT 4'h7
`define BCR_RC_SRX_START 4'h8
`define BCR_RC_SRX_FULL 4'h9
`define BCR_RC_SRX_DONE 4'ha
`define BCR_RC_SRX_SHORT 4'hb

// ==========================================================================
// Event kinds reported by the frame engine on the link
`define BCR_EV_ARB_WON 4'h0
`define BCR_EV_CTRL 4'h1
`define BCR_EV_TX_DONE 4'h2
`define BCR_EV_TX_SHORT 4'h3
`define BCR_EV_ARB_LOST 4'h4
`define BCR_EV_LEN_OK 4'h5
`define BCR_EV_RX_BYTE 4'h6
`define BCR_EV_RX_DONE 4'h7
`define BCR_EV_RX_SHORT 4'h8
`define BCR_EV_TX_FETCH 4'h9

// ==========================================================================
// Sizes, limits and reset values
`define BCR_WDB_DEPTH 3'd4
`define BCR_RDB_DEPTH 5'd20
`define BCR_RDB_LAST 5'd19
`define BCR_ATTEMPTS 2'd3
`define BCR_REPLY_MAX 8'h40
`define BCR_RST_RC 4'h0
`define BCR_RST_RXDIS 1'b0

`endif

/* src/bcr_top.v */
// Command interpreter and return-code reporting of the vehicle-bus controller
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - Cancel clears write buffer and pending reply
// - Load reply answers read control bits 3H/7H
// - First reply parameter is byte count 1..40H; range is not checked here
// - Reply valid until read request, cancel, reset
// - Valid reply drains from write data buffer
// - Reply load accepted even if slave halted
// - Lock command pushes lock status byte
// - Then pushes 12-bit locking unit address
// - Parameter 00H disables reception, empties buffer
// - Parameter 01H enables reception
// - Any other command enables reception
// - Receive enable pops parameter, clears buffer
// - Events post 4-bit code and raise interrupt
// - Code 0000 on arbitration win or on read request while a reply is valid
// - Code 0010 on full transmission in frame
// - Code 0011 on short transmission, three attempts
// - Master rx: 0100 length, 0101 per 20 bytes
// - Master rx ends 0110 or 0111, three attempts
// - Slave rx codes 1000, 1001, 1010, 1011
// - Command nibble in command register, params via buffer
// - New code overwrites the return code register
`include "bcr_regs.vh"

module bcr_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire lk_clk,
	input wire lk_evt,
	input wire [3:0] lk_kind,
	input wire lk_role,
	input wire [7:0] lk_data,
	input wire lk_locked,
	input wire [11:0] lk_lock_addr,
	output reg host_interrupt_request,
	output reg rx_disabled,
	output reg reply_valid,
	output reg [7:0] reply_len,
	output reg [7:0] tx_byte,
	output reg tx_byte_valid,
	output reg cancel_stb,
	output reg cmd_stb,
	output reg [3:0] cmd_code
);

	// ======================================================================
	// Lock readout sequencer states
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_LK = 4'b0010;
	localparam [3:0] ST_AH = 4'b0100;
	localparam [3:0] ST_AL = 4'b1000;

	integer i;
	integer j;

	// ======================================================================
	// Link input synchroniser
	wire [27:0] lk_in_w;
	reg [27:0] lk_s1_q;
	reg [27:0] lk_s2_q;
	reg lk_prev_q;

	// All link lines pass two flops together so they stay aligned
	assign lk_in_w = {lk_clk, lk_evt, lk_kind, lk_role, lk_data, lk_locked, lk_lock_addr};
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lk_s1_q <= 28'h0000000;
			lk_s2_q <= 28'h0000000;
			lk_prev_q <= 1'b0;
		end else begin
			lk_s1_q <= lk_in_w;
			lk_s2_q <= lk_s1_q;
			lk_prev_q <= lk_s2_q[27];
		end
	end

	// Fields of the settled copy; event taken on a rising link edge
	wire ev_fire = lk_s2_q[27] & ~lk_prev_q & lk_s2_q[26];
	wire [3:0] ev_kind = lk_s2_q[25:22];
	wire ev_role = lk_s2_q[21];
	wire [7:0] ev_data = lk_s2_q[20:13];
	wire ev_locked = lk_s2_q[12];
	wire [11:0] ev_lock_addr = lk_s2_q[11:0];

	// ======================================================================
	// State declarations
	reg [7:0] wdb_mem_q [0:3];
	reg [1:0] wdb_rd_q;
	reg [1:0] wdb_wr_q;
	reg [2:0] wdb_cnt_q;
	reg [7:0] rdb_mem_q [0:19];
	reg [4:0] rdb_rd_q;
	reg [4:0] rdb_wr_q;
	reg [4:0] rdb_cnt_q;
	reg [3:0] cmd_q;
	reg [3:0] rc_q;
	reg [3:0] seq_q;
	reg [3:0] seq_d;
	reg lock_q;
	reg [11:0] lock_addr_q;
	reg [1:0] loss_cnt_q;
	reg [4:0] rx_cnt_q;

	// ======================================================================
	// APB decode; zero wait states, effects at the completing edge
	wire apb_setup = psel & ~penable;
	wire apb_done = psel & penable & pready;
	wire wr_done = apb_done & pwrite;
	wire rd_done = apb_done & ~pwrite;
	wire hit_cmd = (paddr == `BCR_OFS_CMD);
	wire hit_wdb = (paddr == `BCR_OFS_WDB);
	wire hit_rdb = (paddr == `BCR_OFS_RDB);
	wire hit_rc = (paddr == `BCR_OFS_RC);
	wire hit_stat = (paddr == `BCR_OFS_STAT);
	wire hit_any = hit_cmd | hit_wdb | hit_rdb | hit_rc | hit_stat;

	wire [7:0] wdb_head = wdb_mem_q[wdb_rd_q];
	wire [7:0] rdb_head = rdb_mem_q[rdb_rd_q];
	wire wdb_empty = (wdb_cnt_q == 3'd0);
	wire rdb_empty = (rdb_cnt_q == 5'd0);
	wire seq_busy = ~seq_q[0];

	// ======================================================================
	// Command decode; commands written while a readout runs are ignored
	wire cmd_fire = wr_done & hit_cmd & ~seq_busy;
	wire [3:0] cmd_w = pwdata[3:0];
	wire cmd_cancel = cmd_fire & (cmd_w == `BCR_CMD_CANCEL);
	wire cmd_reply = cmd_fire & (cmd_w == `BCR_CMD_REPLY);
	wire cmd_lock = cmd_fire & (cmd_w == `BCR_CMD_LOCK);
	wire cmd_rxen = cmd_fire & (cmd_w == `BCR_CMD_RXEN);
	wire cmd_fwd = cmd_fire & (cmd_w[3] | ~cmd_w[2]);

	// ======================================================================
	// Event decode into return codes and buffer actions
	reg post_en;
	reg [3:0] post_code;
	reg ev_push;
	reg loss_inc;
	reg loss_clr;
	reg ev_reply_end;
	reg ev_fetch;
	reg rxc_clr;
	reg rxc_inc;
	// Slave-side reception is dropped while reception is disabled
	wire slave_ok = ~ev_role | ~rx_disabled;

	always @* begin
		post_en = 1'b0;
		post_code = `BCR_RC_TX_START;
		ev_push = 1'b0;
		loss_inc = 1'b0;
		loss_clr = 1'b0;
		ev_reply_end = 1'b0;
		ev_fetch = 1'b0;
		rxc_clr = 1'b0;
		rxc_inc = 1'b0;
		if (ev_fire) begin
			case (ev_kind)
			`BCR_EV_ARB_WON: begin
				post_en = 1'b1;
				post_code = `BCR_RC_TX_START;
				loss_clr = 1'b1;
			end
			`BCR_EV_CTRL: begin
				if (ev_role && (ev_data[3:0] == `BCR_CTRL_RD_LOCK ||
					ev_data[3:0] == `BCR_CTRL_RD)) begin
					ev_reply_end = 1'b1;
					if (reply_valid) begin
						post_en = 1'b1;
						post_code = `BCR_RC_TX_START;
					end
				end
			end
			`BCR_EV_TX_DONE: begin
				post_en = 1'b1;
				post_code = `BCR_RC_TX_DONE;
				loss_clr = 1'b1;
			end
			`BCR_EV_TX_SHORT: begin
				post_en = 1'b1;
				post_code = `BCR_RC_TX_SHORT;
				loss_clr = 1'b1;
			end
			`BCR_EV_ARB_LOST: begin
				// Only the loss of the last attempt ends the request
				if (loss_cnt_q == (`BCR_ATTEMPTS - 2'd1)) begin
					post_en = 1'b1;
					post_code = ev_data[0] ? `BCR_RC_MRX_SHORT : `BCR_RC_TX_SHORT;
					loss_clr = 1'b1;
				end else begin
					loss_inc = 1'b1;
				end
			end
			`BCR_EV_LEN_OK: begin
				if (slave_ok) begin
					post_en = 1'b1;
					post_code = ev_role ? `BCR_RC_SRX_START : `BCR_RC_MRX_START;
					rxc_clr = 1'b1;
					loss_clr = 1'b1;
				end
			end
			`BCR_EV_RX_BYTE: begin
				if (slave_ok) begin
					ev_push = 1'b1;
					// Every twentieth byte asks the host to drain
					if (rx_cnt_q == `BCR_RDB_LAST) begin
						post_en = 1'b1;
						post_code = ev_role ? `BCR_RC_SRX_FULL : `BCR_RC_MRX_FULL;
						rxc_clr = 1'b1;
					end else begin
						rxc_inc = 1'b1;
					end
				end
			end
			`BCR_EV_RX_DONE: begin
				if (slave_ok) begin
					post_en = 1'b1;
					post_code = ev_role ? `BCR_RC_SRX_DONE : `BCR_RC_MRX_DONE;
				end
			end
			`BCR_EV_RX_SHORT: begin
				if (slave_ok) begin
					post_en = 1'b1;
					post_code = ev_role ? `BCR_RC_SRX_SHORT : `BCR_RC_MRX_SHORT;
				end
			end
			`BCR_EV_TX_FETCH: begin
				ev_fetch = 1'b1;
			end
			default: begin
			end
			endcase
		end
	end

	// ======================================================================
	// Lock readout sequencer: status byte, then address high, then low
	reg seq_push;
	reg [7:0] seq_byte;
	always @* begin
		seq_d = seq_q;
		seq_push = 1'b0;
		seq_byte = `BCR_LOCK_NO;
		case (seq_q)
		ST_IDLE: begin
			if (cmd_lock)
				seq_d = ST_LK;
		end
		ST_LK: begin
			seq_push = 1'b1;
			seq_byte = lock_q ? `BCR_LOCK_YES : `BCR_LOCK_NO;
			seq_d = ST_AH;
		end
		ST_AH: begin
			seq_push = 1'b1;
			seq_byte = {4'h0, lock_addr_q[11:8]};
			seq_d = ST_AL;
		end
		ST_AL: begin
			seq_push = 1'b1;
			seq_byte = lock_addr_q[7:0];
			seq_d = ST_IDLE;
		end
		default: begin
			seq_d = ST_IDLE;
		end
		endcase
	end

	// ======================================================================
	// Buffer control terms
	wire wdb_push = wr_done & hit_wdb & (wdb_cnt_q != `BCR_WDB_DEPTH);
	wire fetch_ok = ev_fetch & reply_valid & ~wdb_empty;
	wire wdb_pop = (cmd_reply | fetch_ok) & ~wdb_empty;
	wire wdb_clear = cmd_cancel | cmd_rxen;
	wire rxen_off = cmd_rxen & (wdb_head == `BCR_RXEN_OFF);
	wire rxen_on = cmd_rxen & (wdb_head == `BCR_RXEN_ON);
	wire rdb_push = (seq_push | ev_push) & (rdb_cnt_q != `BCR_RDB_DEPTH);
	wire [7:0] rdb_byte = seq_push ? seq_byte : ev_data;
	wire rdb_pop = rd_done & hit_rdb & ~rdb_empty;
	wire [4:0] rdb_wr_nx = (rdb_wr_q == `BCR_RDB_LAST) ? 5'd0 : rdb_wr_q + 5'd1;
	wire [4:0] rdb_rd_nx = (rdb_rd_q == `BCR_RDB_LAST) ? 5'd0 : rdb_rd_q + 5'd1;

	// ======================================================================
	// Write data buffer; a full buffer drops host writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < 4; i = i + 1)
				wdb_mem_q[i] <= 8'h00;
			wdb_rd_q <= 2'd0;
			wdb_wr_q <= 2'd0;
			wdb_cnt_q <= 3'd0;
		end else if (wdb_clear) begin
			wdb_rd_q <= 2'd0;
			wdb_wr_q <= 2'd0;
			wdb_cnt_q <= 3'd0;
		end else begin
			if (wdb_push) begin
				wdb_mem_q[wdb_wr_q] <= pwdata[7:0];
				wdb_wr_q <= wdb_wr_q + 2'd1;
			end
			if (wdb_pop)
				wdb_rd_q <= wdb_rd_q + 2'd1;
			if (wdb_push && !wdb_pop)
				wdb_cnt_q <= wdb_cnt_q + 3'd1;
			else if (!wdb_push && wdb_pop)
				wdb_cnt_q <= wdb_cnt_q - 3'd1;
		end
	end

	// ======================================================================
	// Read data buffer; disabling reception empties it at once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (j = 0; j < 20; j = j + 1)
				rdb_mem_q[j] <= 8'h00;
			rdb_rd_q <= 5'd0;
			rdb_wr_q <= 5'd0;
			rdb_cnt_q <= 5'd0;
		end else if (rxen_off) begin
			rdb_rd_q <= 5'd0;
			rdb_wr_q <= 5'd0;
			rdb_cnt_q <= 5'd0;
		end else begin
			if (rdb_push) begin
				rdb_mem_q[rdb_wr_q] <= rdb_byte;
				rdb_wr_q <= rdb_wr_nx;
			end
			if (rdb_pop)
				rdb_rd_q <= rdb_rd_nx;
			if (rdb_push && !rdb_pop)
				rdb_cnt_q <= rdb_cnt_q + 5'd1;
			else if (!rdb_push && rdb_pop)
				rdb_cnt_q <= rdb_cnt_q - 5'd1;
		end
	end

	// ======================================================================
	// Command state, reply state, counters and return code
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q <= 4'h0;
			seq_q <= ST_IDLE;
			lock_q <= 1'b0;
			lock_addr_q <= 12'h000;
			rx_disabled <= `BCR_RST_RXDIS;
			reply_valid <= 1'b0;
			reply_len <= 8'h00;
			loss_cnt_q <= 2'd0;
			rx_cnt_q <= 5'd0;
			rc_q <= `BCR_RST_RC;
			host_interrupt_request <= 1'b0;
			tx_byte <= 8'h00;
			tx_byte_valid <= 1'b0;
			cancel_stb <= 1'b0;
			cmd_stb <= 1'b0;
			cmd_code <= 4'h0;
		end else begin
			seq_q <= seq_d;
			if (cmd_fire)
				cmd_q <= cmd_w;
			// Snapshot so the three bytes describe one instant
			if (cmd_lock) begin
				lock_q <= ev_locked;
				lock_addr_q <= ev_lock_addr;
			end
			if (rxen_off)
				rx_disabled <= 1'b1;
			else if (rxen_on || (cmd_fire && !cmd_rxen))
				rx_disabled <= 1'b0;
			// A new load in the same cycle as a read request survives
			if (cmd_reply) begin
				reply_valid <= 1'b1;
				reply_len <= wdb_head;
			end else if (cmd_cancel || ev_reply_end) begin
				reply_valid <= 1'b0;
			end
			if (loss_clr || cmd_cancel || cmd_fwd)
				loss_cnt_q <= 2'd0;
			else if (loss_inc)
				loss_cnt_q <= loss_cnt_q + 2'd1;
			if (rxc_clr)
				rx_cnt_q <= 5'd0;
			else if (rxc_inc)
				rx_cnt_q <= rx_cnt_q + 5'd1;
			if (post_en)
				rc_q <= post_code;
			// Posting wins over a clearing read in the same cycle
			if (post_en)
				host_interrupt_request <= 1'b1;
			else if (rd_done && hit_rc)
				host_interrupt_request <= 1'b0;
			tx_byte_valid <= fetch_ok;
			if (fetch_ok)
				tx_byte <= wdb_head;
			cancel_stb <= cmd_cancel;
			cmd_stb <= cmd_fwd;
			if (cmd_fwd)
				cmd_code <= cmd_w;
		end
	end

	// ======================================================================
	// APB answer, registered in the setup cycle
	reg [31:0] prdata_d;
	always @* begin
		prdata_d = 32'h00000000;
		if (hit_cmd)
			prdata_d = {28'h0000000, cmd_q};
		else if (hit_wdb)
			prdata_d = {29'h00000000, wdb_cnt_q};
		else if (hit_rdb)
			prdata_d = {24'h000000, rdb_empty ? 8'h00 : rdb_head};
		else if (hit_rc)
			prdata_d = {23'h000000, host_interrupt_request, 4'h0, rc_q};
		else if (hit_stat)
			prdata_d = {19'h00000, rdb_cnt_q, seq_busy, wdb_cnt_q, 2'b00,
				rx_disabled, reply_valid};
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (apb_setup) begin
			prdata <= prdata_d;
			pready <= 1'b1;
			pslverr <= ~hit_any;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule // bcr_top

/* test/bcr_link_model.sv */
// Behavioural frame engine that posts link events and the lock state
`timescale 1ns/1ps
module bcr_link_model (
	output logic lk_clk,
	output logic lk_evt,
	output logic [3:0] lk_kind,
	output logic lk_role,
	output logic [7:0] lk_data,
	output logic lk_locked,
	output logic [11:0] lk_lock_addr
);
	// Link idles low between frames
	initial begin
		lk_clk = 1'b0;
		lk_evt = 1'b0;
		lk_kind = 4'hf;
		lk_role = 1'b0;
		lk_data = 8'h00;
		lk_locked = 1'b0;
		lk_lock_addr = 12'h000;
	end
	// One event per 125 ns link period, stable around the rising edge
	task automatic send(input logic [3:0] k, input logic r, input logic [7:0] d);
		lk_evt = 1'b1;
		lk_kind = k;
		lk_role = r;
		lk_data = d;
		#62.5 lk_clk = 1'b1;
		#62.5 lk_clk = 1'b0;
		// Released lines show garbage so stale values never pass for data
		lk_evt = 1'b0;
		lk_kind = ~k;
		lk_data = ~d;
	endtask
	task automatic set_lock(input logic l, input logic [11:0] a);
		lk_locked = l;
		lk_lock_addr = a;
	endtask
endmodule // bcr_link_model

/* test/bcr_top_monitor.sv */
// Port checker for the command and return-code block
`timescale 1ns/1ps
`include "bcr_regs.vh"
module bcr_top_monitor (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire host_interrupt_request,
	input wire rx_disabled,
	input wire reply_valid,
	input wire tx_byte_valid,
	input wire cancel_stb,
	input wire cmd_stb,
	input wire [3:0] cmd_code
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Helpers
	logic [1:0] busy_q;
	wire done = psel && penable && pready;
	wire wr_cmd = done && pwrite && paddr == `BCR_OFS_CMD && busy_q == 2'd0;
	wire rd_rc = done && !pwrite && paddr == `BCR_OFS_RC;
	wire [3:0] code = pwdata[3:0];
	// Commands during the lock readout are dropped, so keep them out of the antecedents
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy_q <= 2'd0;
		else if (wr_cmd && code == `BCR_CMD_LOCK)
			busy_q <= 2'd3;
		else if (busy_q != 2'd0)
			busy_q <= busy_q - 2'd1;
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	// ==========================================================
	// Assertions
	a_ready_one_cycle: assert property (s_setup |=> s_answer)
		else $error("pready is not a single access cycle");
	a_unmapped_error: assert property (done && paddr == 12'h014 |-> pslverr)
		else $error("unmapped access without pslverr");
	a_cancel_reply: assert property (wr_cmd && code == `BCR_CMD_CANCEL |=> !reply_valid)
		else $error("reply survives cancel");
	a_cancel_pulse: assert property (wr_cmd && code == `BCR_CMD_CANCEL |->
		##[1:2] cancel_stb ##1 !cancel_stb)
		else $error("cancel strobe missing or too long");
	a_reply_loaded: assert property (wr_cmd && code == `BCR_CMD_REPLY |-> ##[1:2] reply_valid)
		else $error("reply load not taken");
	a_rx_enabled: assert property (wr_cmd && code != `BCR_CMD_RXEN |-> ##[1:2] !rx_disabled)
		else $error("reception left disabled after a command");
	a_fwd_cmd: assert property (wr_cmd && code == 4'h2 |->
		##[1:2] (cmd_stb && cmd_code == 4'h2))
		else $error("forwarded command lost");
	a_irq_holds: assert property (host_interrupt_request && !rd_rc |=> host_interrupt_request)
		else $error("interrupt dropped without a code read");
	a_stat_mirror: assert property (done && !pwrite && paddr == `BCR_OFS_STAT |->
		prdata[1] == rx_disabled)
		else $error("status bit 1 differs from rx_disabled");
	a_fetch_pulse: assert property (tx_byte_valid |=> !tx_byte_valid)
		else $error("reply byte strobe longer than a cycle");
endmodule // bcr_top_monitor

bind bcr_top bcr_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .host_interrupt_request(host_interrupt_request),
	.rx_disabled(rx_disabled), .reply_valid(reply_valid), .tx_byte_valid(tx_byte_valid),
	.cancel_stb(cancel_stb), .cmd_stb(cmd_stb), .cmd_code(cmd_code));

/* test/tb_bus_command_return_codes.sv */
// Self-checking bench of the command and return-code block
`timescale 1ns/1ps
`include "bcr_regs.vh"
module tb_bus_command_return_codes;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr, lk_lock_addr;
	logic [31:0] pwdata, prdata, rdv;
	logic lk_clk, lk_evt, lk_role, lk_locked, host_interrupt_request, rx_disabled;
	logic reply_valid, tx_byte_valid, cancel_stb, cmd_stb;
	logic [3:0] lk_kind, cmd_code;
	logic [7:0] lk_data, reply_len, tx_byte, last_tx;
	int n_mismatch = 0;
	int cmp_count = 0;
	typedef struct packed {
		logic [3:0] k;
		logic r;
		logic [7:0] d;
		logic [4:0] n;
		logic [3:0] rc;
		logic irq;
	} bcr_row_t;
	// Event, role, data, repeat count -> return code and interrupt
	bcr_row_t rows [16] = '{
		{`BCR_EV_ARB_WON, 1'b0, 8'h00, 5'd1, 4'h0, 1'b1},
		{`BCR_EV_TX_DONE, 1'b0, 8'h00, 5'd1, 4'h2, 1'b1},
		{`BCR_EV_ARB_LOST, 1'b0, 8'h00, 5'd2, 4'h2, 1'b0},
		{`BCR_EV_ARB_LOST, 1'b0, 8'h00, 5'd1, 4'h3, 1'b1},
		{`BCR_EV_ARB_WON, 1'b0, 8'h00, 5'd1, 4'h0, 1'b1},
		{`BCR_EV_ARB_LOST, 1'b0, 8'h01, 5'd3, 4'h7, 1'b1},
		{`BCR_EV_TX_SHORT, 1'b0, 8'h00, 5'd1, 4'h3, 1'b1},
		{`BCR_EV_LEN_OK, 1'b0, 8'h00, 5'd1, 4'h4, 1'b1},
		{`BCR_EV_RX_BYTE, 1'b0, 8'h5a, 5'd19, 4'h4, 1'b0},
		{`BCR_EV_RX_BYTE, 1'b0, 8'h5a, 5'd1, 4'h5, 1'b1},
		{`BCR_EV_RX_DONE, 1'b0, 8'h00, 5'd1, 4'h6, 1'b1},
		{`BCR_EV_RX_SHORT, 1'b0, 8'h00, 5'd1, 4'h7, 1'b1},
		{`BCR_EV_LEN_OK, 1'b1, 8'h00, 5'd1, 4'h8, 1'b1},
		{`BCR_EV_RX_BYTE, 1'b1, 8'hc3, 5'd20, 4'h9, 1'b1},
		{`BCR_EV_RX_DONE, 1'b1, 8'h00, 5'd1, 4'ha, 1'b1},
		{`BCR_EV_RX_SHORT, 1'b1, 8'h00, 5'd1, 4'hb, 1'b1}};

	bcr_top u_bcr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lk_clk(lk_clk), .lk_evt(lk_evt), .lk_kind(lk_kind),
		.lk_role(lk_role), .lk_data(lk_data), .lk_locked(lk_locked),
		.lk_lock_addr(lk_lock_addr), .host_interrupt_request(host_interrupt_request),
		.rx_disabled(rx_disabled), .reply_valid(reply_valid), .reply_len(reply_len),
		.tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .cancel_stb(cancel_stb),
		.cmd_stb(cmd_stb), .cmd_code(cmd_code));
	bcr_link_model u_bcr_link_model (.lk_clk(lk_clk), .lk_evt(lk_evt), .lk_kind(lk_kind),
		.lk_role(lk_role), .lk_data(lk_data), .lk_locked(lk_locked),
		.lk_lock_addr(lk_lock_addr));

	// ==========================================================
	// Clock, capture and tasks
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// The reply byte is flagged valid for one cycle only, so catch it here
	always @(posedge pclk) begin
		if (tx_byte_valid === 1'b1)
			last_tx <= tx_byte;
	end
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// One APB transfer; the request holds until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20) begin
			n_mismatch++;
			finish_test;
		end
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ev(input logic [3:0] k, input logic r, input logic [7:0] d);
		u_bcr_link_model.send(k, r, d);
		repeat (6) @(posedge pclk);
	endtask
	task automatic rc_is(input logic [3:0] c, input logic q);
		apb(1'b0, `BCR_OFS_RC, 32'h0);
		chk({27'h0, rdv[8], rdv[3:0]}, {27'h0, q, c});
		// Interrupt drops at the read's completing edge; look once it has settled
		@(negedge pclk);
		chk(32'(host_interrupt_request), 32'h0);
	endtask
	task automatic run(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			for (int j = 0; j < rows[i].n; j++)
				ev(rows[i].k, rows[i].r, rows[i].d);
			rc_is(rows[i].rc, rows[i].irq);
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		last_tx = 8'h00;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rc_is(4'h0, 1'b0);
		run(0, 11);
		// Disabling reception empties both buffers and stops slave events
		apb(1'b1, `BCR_OFS_WDB, 32'h0);
		apb(1'b1, `BCR_OFS_CMD, 32'h7);
		apb(1'b0, `BCR_OFS_STAT, 32'h0);
		chk({rdv[12:8], rdv[6:4], rdv[1]}, 32'h1);
		ev(`BCR_EV_LEN_OK, 1'b1, 8'h00);
		rc_is(4'h7, 1'b0);
		apb(1'b1, `BCR_OFS_WDB, 32'h1);
		apb(1'b1, `BCR_OFS_CMD, 32'h7);
		apb(1'b0, `BCR_OFS_STAT, 32'h0);
		chk(32'(rdv[1]), 32'h0);
		run(12, 15);
		// Reply of three bytes, drained by the link, then claimed by a read request
		apb(1'b1, `BCR_OFS_WDB, 32'h3);
		apb(1'b1, `BCR_OFS_WDB, 32'haa);
		apb(1'b1, `BCR_OFS_WDB, 32'hbb);
		apb(1'b1, `BCR_OFS_CMD, 32'h5);
		apb(1'b0, `BCR_OFS_STAT, 32'h0);
		chk({reply_len, rdv[6:4], rdv[0]}, 32'h35);
		ev(`BCR_EV_TX_FETCH, 1'b1, 8'h00);
		chk(32'(last_tx), 32'haa);
		// Drain the second byte so no stale byte leaks into the next load
		ev(`BCR_EV_TX_FETCH, 1'b1, 8'h00);
		chk(32'(last_tx), 32'hbb);
		ev(`BCR_EV_CTRL, 1'b1, 8'h03);
		chk(32'(reply_valid), 32'h0);
		rc_is(4'h0, 1'b1);
		// Cancel right after a load drops the reply and the buffered bytes
		apb(1'b1, `BCR_OFS_WDB, 32'h1);
		apb(1'b1, `BCR_OFS_WDB, 32'hcc);
		apb(1'b1, `BCR_OFS_CMD, 32'h5);
		apb(1'b1, `BCR_OFS_CMD, 32'h4);
		apb(1'b0, `BCR_OFS_STAT, 32'h0);
		chk({rdv[6:4], rdv[0]}, 32'h0);
		chk(32'(reply_len), 32'h1);
		// Lock readout from an empty read buffer; reception was disabled, and the lock command enables it again
		u_bcr_link_model.set_lock(1'b1, 12'h3a5);
		apb(1'b1, `BCR_OFS_WDB, 32'h0);
		apb(1'b1, `BCR_OFS_CMD, 32'h7);
		apb(1'b1, `BCR_OFS_CMD, 32'h6);
		repeat (4) @(posedge pclk);
		chk(32'(rx_disabled), 32'h0);
		apb(1'b0, `BCR_OFS_RDB, 32'h0);
		chk(rdv[7:0], `BCR_LOCK_YES);
		apb(1'b0, `BCR_OFS_RDB, 32'h0);
		chk(rdv[7:0], 32'h03);
		apb(1'b0, `BCR_OFS_RDB, 32'h0);
		chk(rdv[7:0], 32'ha5);
		apb(1'b1, `BCR_OFS_CMD, 32'h2);
		apb(1'b0, `BCR_OFS_CMD, 32'h0);
		chk(rdv[3:0], 32'h2);
		apb(1'b0, 12'h014, 32'h0);
		chk(32'(err), 32'h1);
		// A reset in mid-run voids a loaded reply
		apb(1'b1, `BCR_OFS_WDB, 32'h1);
		apb(1'b1, `BCR_OFS_CMD, 32'h5);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		chk(32'(reply_valid), 32'h0);
		rc_is(4'h0, 1'b0);
		finish_test;
	end
	// Watchdog well beyond the expected run of about 13 us
	initial begin
		#300000;
		n_mismatch++;
		finish_test;
	end
endmodule // tb_bus_command_return_codes
